// ===== design/sio_defs.vh
// Register map, field positions, reset values and timing counts for the strobe and I/O block
`ifndef SIO_DEFS_VH
`define SIO_DEFS_VH
`define SIO_OFF_CH0 8'h00
`define SIO_OFF_CH1 8'h04
`define SIO_OFF_CH2 8'h08
`define SIO_OFF_CH3 8'h0C
`define SIO_OFF_OUT 8'h10
`define SIO_OFF_IN 8'h14
`define SIO_OFF_PCFG 8'h18
`define SIO_F_EN 31
`define SIO_F_POL 30
`define SIO_F_DLY_HI 23
`define SIO_F_DLY_LO 12
`define SIO_F_DUR_HI 11
`define SIO_F_DUR_LO 0
`define SIO_F_PORT_HI 31
`define SIO_F_PORT_LO 28
`define SIO_CH_RST 32'h00000000
`define SIO_OUT_RST 4'h0
`define SIO_PCFG_RST 8'h00
`define SIO_SRC_USER 2'h0
`define SIO_SRC_STROBE 2'h1
`define SIO_CLK_HZ 50000000
`define SIO_TICK_PER_S 1024000
`define SIO_TICK_NUM 1024
`define SIO_TICK_DEN 50000
`define SIO_RESP_OKAY 2'h0
`define SIO_RESP_SLVERR 2'h2
`endif

// ===== design/sio_tick.v
// Fractional divider making the 1/1024 ms tick from the core clock
`timescale 1ns/1ps
`include "sio_defs.vh"
module sio_tick (
  input wire clk,
  input wire arst_n,
  input wire ce,
  output reg tick
);
  // Accumulate 1024 per clock against 50000: average exactly 1024 ticks per ms
  reg [15:0] acc_q;
  wire [16:0] sum = {1'b0, acc_q} + 17'd`SIO_TICK_NUM;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 16'h0000;
      tick <= 1'b0;
    end else if (ce) begin
      if (sum >= 17'd`SIO_TICK_DEN) begin // [RULE_14]
        acc_q <= sum[15:0] - 16'd`SIO_TICK_DEN;
        tick <= 1'b1;
      end else begin
        acc_q <= sum[15:0];
        tick <= 1'b0;
      end
    end
  end
endmodule // sio_tick

// ===== design/sio_strobe.v
// One strobe pulse generator: delay then duration, restarted by exposure start
`timescale 1ns/1ps
`include "sio_defs.vh"
module sio_strobe (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire tick,
  input wire expo,
  input wire en,
  input wire pol,
  input wire [11:0] dly,
  input wire [11:0] dur,
  output reg pin
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_DLY = 2'h1;
  localparam [1:0] S_ACT = 2'h2;
  reg [1:0] st_q;
  reg [11:0] cnt_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_IDLE;
      cnt_q <= 12'h000;
    end else if (ce) begin
      if (!en) begin
        st_q <= S_IDLE; // [RULE_02]
      end else if (expo) begin
        // Running strobe dropped, fresh delay starts
        st_q <= S_DLY; // [RULE_05] [RULE_09]
        cnt_q <= dly;
      end else begin
        case (st_q)
          S_DLY: begin
            if (cnt_q == 12'h000) begin
              st_q <= (dur == 12'h000) ? S_IDLE : S_ACT;
              cnt_q <= dur; // [RULE_06]
            end else if (tick) begin
              cnt_q <= cnt_q - 12'h001; // [RULE_04]
            end
          end
          S_ACT: begin
            if (tick) begin
              if (cnt_q == 12'h001) begin
                st_q <= S_IDLE;
              end
              cnt_q <= cnt_q - 12'h001;
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end
  always @* begin
    pin = (st_q == S_ACT) ? pol : ~pol; // [RULE_03] [RULE_13]
  end
endmodule // sio_strobe

// ===== design/sio_top.v
// Strobe generators, parallel output/input ports and AXI4-Lite register slave
// Summary of operation
// [RULE_01] Four independent strobe channels, zero to three
// [RULE_02] Channel pulses only while enable is one
// [RULE_03] Polarity one active high, zero active low
// [RULE_04] Delay 0..4095 ticks of 1/1024 ms
// [RULE_05] Delay counts from exposure start to active
// [RULE_06] Duration 0..4095 ticks after delay expires
// [RULE_07] Unassigned strobe drives no pin
// [RULE_08] Strobe N only to output port N
// [RULE_09] New exposure restarts running strobe immediately
// [RULE_10] Output write bits 31..28 set ports 0..3
// [RULE_11] Written bits affect only user-set ports
// [RULE_12] Input read gives ports 0..3 in 31..28
// [RULE_13] Idle, disabled or delaying output is inactive
// [RULE_14] Derive 1/1024 ms tick from core clock
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sio_defs.vh"
module sio_top #(
  parameter NCH = 4
) (
  input wire MCLK,
  input wire ARST_N,
  input wire CE,
  input wire EXPO_START,
  input wire [3:0] IN_PORT,
  output reg [3:0] OUT_PORT,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  reg [31:0] ch_q [0:NCH-1];
  reg [3:0] user_q;
  reg [7:0] pcfg_q;
  reg [3:0] in_m_q;
  reg [3:0] in_s_q;
  reg expo_m_q;
  reg expo_s_q;
  reg expo_p_q;
  reg [7:0] aw_q;
  reg aw_ok_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  reg w_ok_q;
  wire tick;
  wire [NCH-1:0] strobe;
  wire [NCH-1:0] out_d;
  wire expo_rise = expo_s_q & ~expo_p_q;

  // Exposure start and input pins come from outside: two-stage sync
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_m_q <= 4'h0;
      in_s_q <= 4'h0;
      expo_m_q <= 1'b0;
      expo_s_q <= 1'b0;
      expo_p_q <= 1'b0;
    end else if (CE) begin
      in_m_q <= IN_PORT;
      in_s_q <= in_m_q;
      expo_m_q <= EXPO_START;
      expo_s_q <= expo_m_q;
      expo_p_q <= expo_s_q;
    end
  end

  sio_tick u_tick (
    .clk(MCLK),
    .arst_n(ARST_N),
    .ce(CE),
    .tick(tick)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      sio_strobe u_str ( // [RULE_01]
        .clk(MCLK),
        .arst_n(ARST_N),
        .ce(CE),
        .tick(tick),
        .expo(expo_rise),
        .en(ch_q[g][`SIO_F_EN]),
        .pol(ch_q[g][`SIO_F_POL]),
        .dly(ch_q[g][`SIO_F_DLY_HI:`SIO_F_DLY_LO]),
        .dur(ch_q[g][`SIO_F_DUR_HI:`SIO_F_DUR_LO]),
        .pin(strobe[g])
      );
      // Port g can only take strobe g; any other source leaves the user level
      assign out_d[g] = (pcfg_q[2*g+1 -: 2] == `SIO_SRC_STROBE) ? // [RULE_07] [RULE_08]
        strobe[g] : user_q[g];
    end
  endgenerate

  // One register for all ports keeps a single driver on the output
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OUT_PORT <= 4'h0;
    end else if (CE) begin
      OUT_PORT <= out_d;
    end
  end

  // Write channel: address and data accepted in either order
  wire wr_go = aw_ok_q & w_ok_q & ~S_AXI_BVALID;
  integer i;
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_q <= 8'h00;
      aw_ok_q <= 1'b0;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
      w_ok_q <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `SIO_RESP_OKAY;
      user_q <= `SIO_OUT_RST;
      pcfg_q <= `SIO_PCFG_RST;
      for (i = 0; i < NCH; i = i + 1) begin
        ch_q[i] <= `SIO_CH_RST;
      end
    end else if (CE) begin
      S_AXI_AWREADY <= ~aw_ok_q & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY <= ~w_ok_q & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_q <= S_AXI_AWADDR;
        aw_ok_q <= 1'b1;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_q <= S_AXI_WDATA;
        ws_q <= S_AXI_WSTRB;
        w_ok_q <= 1'b1;
      end
      if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_go) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `SIO_RESP_OKAY;
        if (aw_q[7:4] == 4'h0) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (ws_q[i]) begin
              ch_q[aw_q[3:2]][8*i +: 8] <= w_q[8*i +: 8];
            end
          end
        end else if (aw_q == `SIO_OFF_OUT) begin
          if (ws_q[3]) begin
            // Only bits 31..28 used, bit 31 to port 0
            for (i = 0; i < 4; i = i + 1) begin
              if (pcfg_q[2*i+1 -: 2] == `SIO_SRC_USER) begin // [RULE_11]
                user_q[i] <= w_q[`SIO_F_PORT_HI - i]; // [RULE_10]
              end
            end
          end
        end else if (aw_q == `SIO_OFF_PCFG) begin
          if (ws_q[0]) begin
            pcfg_q <= w_q[7:0];
          end
        end else if (aw_q != `SIO_OFF_IN) begin
          S_AXI_BRESP <= `SIO_RESP_SLVERR;
        end
      end
    end
  end

  // Read channel: one cycle from address to data
  reg [31:0] rd_d;
  reg rd_err_d;
  always @* begin
    rd_d = 32'h00000000;
    rd_err_d = 1'b0;
    if (S_AXI_ARADDR[7:4] == 4'h0) begin
      rd_d = ch_q[S_AXI_ARADDR[3:2]];
    end else if (S_AXI_ARADDR == `SIO_OFF_OUT) begin
      rd_d = {user_q[0], user_q[1], user_q[2], user_q[3], 28'h0000000};
    end else if (S_AXI_ARADDR == `SIO_OFF_IN) begin
      rd_d = {in_s_q[0], in_s_q[1], in_s_q[2], in_s_q[3], 28'h0000000}; // [RULE_12]
    end else if (S_AXI_ARADDR == `SIO_OFF_PCFG) begin
      rd_d = {24'h000000, pcfg_q};
    end else begin
      rd_err_d = 1'b1;
    end
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `SIO_RESP_OKAY;
    end else if (CE) begin
      S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_d;
        S_AXI_RRESP <= rd_err_d ? `SIO_RESP_SLVERR : `SIO_RESP_OKAY;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule // sio_top

// ===== verification/sio_top_asserts.sv
// Bus handshake checks for the strobe and I/O block
`timescale 1ns/1ps
module sio_asserts (
  input wire MCLK,
  input wire ARST_N,
  input wire CE,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [1:0] S_AXI_RRESP,
  input wire [31:0] S_AXI_RDATA,
  input wire [3:0] OUT_PORT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  chk_aw_pulse: assert property (S_AXI_AWREADY && CE |=> !S_AXI_AWREADY)
    else $error("write address ready held too long");
  // The later of address and data decides when the response comes
  chk_b_answer: assert property ($rose(S_AXI_BVALID) |->
    $past(S_AXI_WREADY, 2) || $past(S_AXI_AWREADY, 2))
    else $error("write response not two cycles after address and data");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  chk_b_code: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0 || S_AXI_BRESP == 2'h2)
    else $error("write response code illegal");
  chk_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY && CE |=> S_AXI_RVALID)
    else $error("read data late");
  chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while data pending");
  chk_err_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |->
    S_AXI_RDATA == 32'h0)
    else $error("error read carries data");
  cover property ($rose(OUT_PORT[0]));
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule // sio_asserts
bind sio_top sio_asserts u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .CE(CE),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RDATA(S_AXI_RDATA), .OUT_PORT(OUT_PORT));

// ===== verification/sio_lamp.sv
// Exposure trigger source and input wiring seen by the block
`timescale 1ns/1ps
module sio_lamp (
  input wire clk,
  input wire fire,
  output logic expo,
  output wire [3:0] in_port
);
  logic [3:0] cnt_q = 4'h0;
  assign in_port = 4'h5;
  // Long enough to survive the two-stage input synchroniser
  always @(posedge clk) begin
    cnt_q <= fire ? 4'h8 : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
    expo <= fire || cnt_q > 4'h1;
  end
  initial expo = 1'b0;
endmodule // sio_lamp

// ===== verification/test_strobe_and_parallel_io.sv
// Self-checking bench for the strobe and I/O block
`timescale 1ns/1ps
module test_strobe_and_parallel_io;
  typedef struct packed {logic [7:0] a; logic [31:0] w, m, e; logic [1:0] br, rr;} sio_row_t;
  sio_row_t rows [6] = '{
    '{8'h00, 32'hC0001002, 32'hFFFFFFFF, 32'hC0001002, 2'h0, 2'h0},
    '{8'h0C, 32'h80000005, 32'hFFFFFFFF, 32'h80000005, 2'h0, 2'h0},
    '{8'h18, 32'h00000001, 32'h000000FF, 32'h00000001, 2'h0, 2'h0},
    '{8'h10, 32'hF0000000, 32'hF0000000, 32'h70000000, 2'h0, 2'h0},
    '{8'h14, 32'hFFFFFFFF, 32'hF0000000, 32'hA0000000, 2'h0, 2'h0},
    '{8'h1C, 32'h12345678, 32'hFFFFFFFF, 32'h00000000, 2'h2, 2'h2}};
  logic MCLK = 0, ARST_N = 0, CE = 1, fire = 0, awv = 0, wv = 0, arv = 0, bready = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] resp;
  wire awr, wrd, bv, arr, rv, expo;
  wire [1:0] br, rr;
  wire [31:0] rd_d;
  wire [3:0] in_port, OUT_PORT;
  int n_errors = 0, checks_done = 0, dl, hi;
  sio_top u_dut (.MCLK(MCLK), .ARST_N(ARST_N), .CE(CE), .EXPO_START(expo), .IN_PORT(in_port),
    .OUT_PORT(OUT_PORT), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_d), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
  sio_lamp u_lamp (.clk(MCLK), .fire(fire), .expo(expo), .in_port(in_port));
  initial forever #10 MCLK = ~MCLK;
  task results;
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(posedge MCLK);
      if (awr === 1) awv <= 0;
      if (wrd === 1) wv <= 0;
    end while (bv !== 1);
    resp = br;
    bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge MCLK);
    araddr <= a; arv <= 1; rready <= 1;
    do begin
      @(posedge MCLK);
      if (arr === 1) arv <= 0;
    end while (rv !== 1);
    resp = rr;
    rdata = rd_d;
    rready <= 0;
  endtask
  // Cycles from trigger to active strobe, capped at 300
  task fire_wait(output int n);
    @(posedge MCLK) fire <= 1;
    @(posedge MCLK) fire <= 0;
    // Past sync and restart latency, so a restarted pulse is seen low first
    repeat (5) @(posedge MCLK);
    n = 5;
    while (OUT_PORT[0] !== 1 && n < 300) begin
      @(posedge MCLK);
      n++;
    end
  endtask
  initial begin
    repeat (16) @(posedge MCLK);
    chk("out_rst", OUT_PORT, 4'h0);
    ARST_N <= 1;
    rd(8'h00); chk("ch0_rst", rdata, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w); chk("bresp", resp, rows[i].br);
      rd(rows[i].a); chk("rresp", resp, rows[i].rr);
      chk("rdata", rdata & rows[i].m, rows[i].e);
    end
    chk("out_user", OUT_PORT, 4'hE);
    fire_wait(dl); chk("delay", dl <= 60, 1);
    hi = 0;
    while (OUT_PORT[0] === 1 && hi < 3000) begin
      @(posedge MCLK);
      hi++;
    end
    chk("duration", hi inside {[94:101]}, 1);
    chk("unrouted", OUT_PORT, 4'hE);
    wr(8'h00, 32'hC0004028);
    fire_wait(dl);
    repeat (50) @(posedge MCLK);
    // Mid-pulse: without a restart the port stays active and the count stops at 5
    fire_wait(dl); chk("restart", dl inside {[144:206]}, 1);
    wr(8'h00, 32'h40001002);
    fire_wait(dl); chk("disabled", dl, 300);
    wr(8'h00, 32'h80001002);
    repeat (4) @(posedge MCLK);
    chk("low_idle", OUT_PORT[0], 1);
    wr(8'h18, 32'h00000000);
    wr(8'h10, 32'h80000000);
    repeat (2) @(posedge MCLK);
    chk("out_order", OUT_PORT, 4'h1);
    ARST_N <= 0;
    repeat (2) @(posedge MCLK);
    chk("out_rst2", OUT_PORT, 4'h0);
    ARST_N <= 1;
    rd(8'h00); chk("ch0_rst2", rdata, 32'h0);
    results;
  end
  initial begin
    #1000000;
    n_errors++;
    results;
  end
endmodule // test_strobe_and_parallel_io
